// File: core/rpds_consts.vh
/*
 * Constants of the regulator power-down sequencer: register indices,
 * field positions, reset values and timing.
 * Assumes inclusion by bare name from core/ design files only.
 */
`ifndef RPDS_CONSTS_VH
`define RPDS_CONSTS_VH

// Register indices; byte address is four times the index
`define RPDS_IDX_BUCK_A       8'h5F
`define RPDS_IDX_BUCK_B       8'h60
`define RPDS_IDX_BUCK_C       8'h61
`define RPDS_IDX_LINREG_A     8'h62
`define RPDS_IDX_LINREG_B     8'h63
`define RPDS_IDX_LINREG_C     8'h64
`define RPDS_IDX_MEMREF       8'h65
`define RPDS_IDX_CTRL         8'h70
`define RPDS_IDX_STATUS       8'h71

`define RPDS_NUM_REGS         7
`define RPDS_ORD_W            3
`define RPDS_ORD_RESET        3'h0
`define RPDS_LVL_TOP          3'h7
`define RPDS_LVL_ZERO         3'h0

// Control register fields
`define RPDS_CTRL_GO_BIT      0
`define RPDS_CTRL_DLY_LSB     8
`define RPDS_CTRL_DLY_MSB     15
`define RPDS_DLY_RESET        8'h02

// Status register fields
`define RPDS_ST_OFF_LSB       0
`define RPDS_ST_OFF_MSB       6
`define RPDS_ST_STATE_LSB     8
`define RPDS_ST_STATE_MSB     9
`define RPDS_ST_INIT_BIT      10
`define RPDS_ST_LVL_LSB       12
`define RPDS_ST_LVL_MSB       14

// Step delay unit: one tick is 1000 ns at a 40 ns clock
`define RPDS_TICK_NS          1000
`define RPDS_CLK_NS           40
`define RPDS_TICK_CYC         ((`RPDS_TICK_NS + `RPDS_CLK_NS - 1) / `RPDS_CLK_NS)
`define RPDS_PRE_W            5
// Last prescaler count of one tick (25 cycles)
`define RPDS_PRE_LAST         5'h18

`define RPDS_ZERO32           32'h0000_0000

`endif

// File: core/rpds_order_reg.v
/*
 * One regulator's 3-bit power-down order register.
 * Assumes the parent supplies a one-cycle init load and a qualified write.
 */
`timescale 1ns/100ps
`include "rpds_consts.vh"

module rpds_order_reg (
    input  wire                    clk,
    input  wire                    nrst,
    input  wire                    ce,
    input  wire                    init_load,
    input  wire [`RPDS_ORD_W-1:0]  init_val,
    input  wire                    wr_en,
    input  wire [`RPDS_ORD_W-1:0]  wr_val,
    output reg  [`RPDS_ORD_W-1:0]  order_r
);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            order_r <= `RPDS_ORD_RESET;
        end else if (ce) begin
            if (init_load) begin
                order_r <= init_val;
            end else if (wr_en) begin
                order_r <= wr_val;
            end
        end
    end

endmodule

// File: core/rpds_sequencer.v
/*
 * Power-down sequencer for seven regulators with APB register access.
 * Assumes an APB master on clk, fuse values stable from reset release,
 * and that the start-up sequencer lives elsewhere.
 */
`timescale 1ns/100ps
`include "rpds_consts.vh"

// What this block does
// - Seven 3-bit off-order fields, bits 7..3 unused
// - Init loads off order from fused on order, or from test_on_orders in test mode
// - Disable regulators by descending order value
// - Host rewrites orders while system is on
// - Start-up order comes only from fuses or their test substitute
// - All orders zero: disable everything at once
// - Shutdown mirrors start-up ordering in reverse
module rpds_sequencer (
    input  wire         clk,
    input  wire         nrst,
    input  wire         ce,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    input  wire         sys_on,
    input  wire         pd_start,
    input  wire         test_mode_config_source,
    input  wire [20:0]  fused_on_orders,
    input  wire [20:0]  test_on_orders,
    output reg  [6:0]   reg_off_r,
    output reg          pd_busy_r,
    output reg          pd_done_r
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_STEP = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;
    localparam [1:0] ST_DONE = 2'b11;

    localparam [`RPDS_PRE_W-1:0] PRE_LAST = `RPDS_PRE_LAST;

    reg  [1:0]                   state_r;
    reg  [`RPDS_ORD_W-1:0]       lvl_r;
    reg  [7:0]                   dly_cfg_r;
    reg  [7:0]                   dly_cnt_r;
    reg  [`RPDS_PRE_W-1:0]       pre_r;
    reg                          init_done_r;
    reg                          go_r;
    reg                          sys_on_d_r;

    wire [20:0]                  orders;
    wire [20:0]                  on_src;
    wire [7:0]                   idx;
    wire [7:0]                   idx_rel;
    wire                         aligned;
    wire                         apb_wr;
    wire                         apb_rd;
    wire                         init_load;
    reg  [6:0]                   ord_wr;
    reg  [6:0]                   match;
    reg                          all_zero;
    reg                          hit_ord;
    reg  [2:0]                   hit_n;
    integer                      i;

    // Start-up order source: fuses or their test substitute, never software
    assign on_src    = test_mode_config_source ? test_on_orders : fused_on_orders;
    assign init_load = !init_done_r;
    assign idx       = paddr[9:2];
    assign idx_rel   = idx - `RPDS_IDX_BUCK_A;
    assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign apb_rd    = psel && penable && !pwrite && pready;
    assign apb_wr    = psel && penable && pwrite && pready;

    genvar g;
    generate
        for (g = 0; g < `RPDS_NUM_REGS; g = g + 1) begin : g_ord
            rpds_order_reg u_ord (
                .clk       (clk),
                .nrst      (nrst),
                .ce        (ce),
                .init_load (init_load),
                .init_val  (on_src[g*3 +: 3]),
                .wr_en     (ord_wr[g]),
                .wr_val    (pwdata[2:0]),
                .order_r   (orders[g*3 +: 3])
            );
        end
    endgenerate

    // Address decode of order registers; writes only while system is on
    always @* begin
        ord_wr = 7'b000_0000;
        hit_ord = 1'b0;
        hit_n = 3'd0;
        if (aligned && idx >= `RPDS_IDX_BUCK_A && idx <= `RPDS_IDX_MEMREF) begin
            hit_ord = 1'b1;
            hit_n = idx_rel[2:0];
        end
        if (apb_wr && hit_ord && sys_on && init_done_r) begin
            ord_wr[hit_n] = 1'b1;
        end
    end

    // Regulators at the current level, and the all-zero bypass test
    always @* begin
        match = 7'b000_0000;
        all_zero = 1'b1;
        for (i = 0; i < `RPDS_NUM_REGS; i = i + 1) begin
            match[i] = (orders[i*3 +: 3] == lvl_r) && !reg_off_r[i];
            if (orders[i*3 +: 3] != `RPDS_ORD_RESET) begin
                all_zero = 1'b0;
            end
        end
    end

    // APB slave: one wait state, pready from a flop
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RPDS_ZERO32;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= `RPDS_ZERO32;
            if (psel && penable && !pready) begin
                if (aligned && hit_ord) begin
                    prdata[2:0] <= orders[hit_n*3 +: 3];
                    pslverr <= pwrite && !(sys_on && init_done_r);
                end else if (aligned && idx == `RPDS_IDX_CTRL) begin
                    prdata[`RPDS_CTRL_DLY_MSB:`RPDS_CTRL_DLY_LSB] <= dly_cfg_r;
                end else if (aligned && idx == `RPDS_IDX_STATUS) begin
                    prdata[`RPDS_ST_OFF_MSB:`RPDS_ST_OFF_LSB] <= reg_off_r;
                    prdata[`RPDS_ST_STATE_MSB:`RPDS_ST_STATE_LSB] <= state_r;
                    prdata[`RPDS_ST_INIT_BIT] <= init_done_r;
                    prdata[`RPDS_ST_LVL_MSB:`RPDS_ST_LVL_LSB] <= lvl_r;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Control register and init flag
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dly_cfg_r <= `RPDS_DLY_RESET;
            go_r <= 1'b0;
            init_done_r <= 1'b0;
        end else if (ce) begin
            init_done_r <= 1'b1;
            if (state_r == ST_IDLE) begin
                go_r <= 1'b0;
            end
            if (apb_wr && aligned && idx == `RPDS_IDX_CTRL) begin
                dly_cfg_r <= pwdata[`RPDS_CTRL_DLY_MSB:`RPDS_CTRL_DLY_LSB];
                if (pwdata[`RPDS_CTRL_GO_BIT]) begin
                    go_r <= 1'b1;
                end
            end
        end
    end

    // Shutdown sequencer, the mirror of start-up: top level downward
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            lvl_r <= `RPDS_LVL_TOP;
            reg_off_r <= 7'b000_0000;
            pd_busy_r <= 1'b0;
            pd_done_r <= 1'b0;
            dly_cnt_r <= 8'h00;
            pre_r <= {`RPDS_PRE_W{1'b0}};
            sys_on_d_r <= 1'b0;
        end else if (ce) begin
            sys_on_d_r <= sys_on;
            case (state_r)
                ST_IDLE: begin
                    if (init_done_r && (pd_start || go_r)) begin
                        pd_busy_r <= 1'b1;
                        lvl_r <= `RPDS_LVL_TOP;
                        state_r <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    if (all_zero) begin
                        reg_off_r <= 7'b111_1111;
                        state_r <= ST_DONE;
                    end else if (match != 7'b000_0000) begin
                        reg_off_r <= reg_off_r | match;
                        dly_cnt_r <= dly_cfg_r;
                        pre_r <= {`RPDS_PRE_W{1'b0}};
                        state_r <= (lvl_r == `RPDS_LVL_ZERO) ? ST_DONE : ST_WAIT;
                    end else if (lvl_r == `RPDS_LVL_ZERO) begin
                        state_r <= ST_DONE;
                    end else begin
                        lvl_r <= lvl_r - 3'd1;
                    end
                end
                ST_WAIT: begin
                    if (dly_cnt_r == 8'h00) begin
                        lvl_r <= lvl_r - 3'd1;
                        state_r <= ST_STEP;
                    end else if (pre_r == PRE_LAST) begin
                        pre_r <= {`RPDS_PRE_W{1'b0}};
                        dly_cnt_r <= dly_cnt_r - 8'h01;
                    end else begin
                        pre_r <= pre_r + {{(`RPDS_PRE_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_DONE: begin
                    pd_busy_r <= 1'b0;
                    pd_done_r <= 1'b1;
                    // A new power-up returns all regulators to the start-up sequencer
                    if (sys_on && !sys_on_d_r) begin
                        reg_off_r <= 7'b000_0000;
                        pd_done_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: tb/rpds_chk.sv
/* Port checker for the power-down sequencer and its APB slave.
   Assumes ce is high whenever a transfer or a start is pending; bound to rpds_sequencer. */
`timescale 1ns/100ps
module rpds_chk (
    input logic        clk,
    input logic        nrst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        pd_start,
    input logic [6:0]  reg_off_r,
    input logic        pd_busy_r,
    input logic        pd_done_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready held");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    chk_order_bits: assert property (pready && !pwrite && paddr[9:2] >= 8'h5F && paddr[9:2] <= 8'h65 |->
        prdata[31:3] == 29'h0) else $error("unused order bits set");
    chk_off_sticky: assert property (pd_busy_r |=> (reg_off_r & $past(reg_off_r)) == $past(reg_off_r))
        else $error("regulator re-enabled");
    chk_done_all: assert property (pd_done_r |-> reg_off_r == 7'h7f)
        else $error("done with regulator on");
    chk_busy_done: assert property ($fell(pd_busy_r) |-> ##[0:1] pd_done_r)
        else $error("busy ended without done");
    chk_start_busy: assert property (pd_start && !pd_busy_r && !pd_done_r |=> pd_busy_r)
        else $error("start ignored");
endmodule
bind rpds_sequencer rpds_chk rpds_chk_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_start(pd_start), .reg_off_r(reg_off_r), .pd_busy_r(pd_busy_r), .pd_done_r(pd_done_r));

// File: tb/rpds_sequencer_tb_top.sv
/* Self-checking bench for the power-down sequencer.
   Assumes a 40 ns clock and the default step delay of 2 ticks. */
`timescale 1ns/100ps
module rpds_sequencer_tb_top;
    logic        clk, nrst, ce, psel, penable, pwrite, sys_on, pd_start, tm_src, pready, pslverr, err;
    logic        pd_busy_r, pd_done_r;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] fuse, tfuse, ord;
    logic [6:0]  reg_off_r;
    int          fail_count, check_count, t[7], k, i, j;
    rpds_sequencer rpds_sequencer_inst (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_on(sys_on), .pd_start(pd_start), .test_mode_config_source(tm_src),
        .fused_on_orders(fuse), .test_on_orders(tfuse), .reg_off_r(reg_off_r), .pd_busy_r(pd_busy_r),
        .pd_done_r(pd_done_r));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function logic [2:0] fld(input logic [20:0] o, input int n);
        return o[3*n +: 3];
    endfunction
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp=%h got=%h", nm, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // pready ends this wait; only the watchdog bounds it
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_reset(input logic tm);
        tm_src <= tm;
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task run_seq(input logic [20:0] o, input logic go);
        int c;
        sys_on <= 1'b1;
        for (i = 0; i < 7; i++) apb(1'b1, 8'h5F + i, {29'($urandom), fld(o, i)});
        for (i = 0; i < 7; i++) begin
            apb(1'b0, 8'h5F + i, 32'h0000_0000);
            chk("order_rd", rd, {29'h0, fld(o, i)});
        end
        if (go) apb(1'b1, 8'h70, 32'h0000_0201);
        else begin
            @(posedge clk) pd_start <= 1'b1;
            @(posedge clk) pd_start <= 1'b0;
        end
        foreach (t[n]) t[n] = -1;
        c = 0;
        while (pd_done_r !== 1'b1 && c < 3000) begin
            @(posedge clk);
            #1 c++;
            for (i = 0; i < 7; i++) if (reg_off_r[i] === 1'b1 && t[i] < 0) t[i] = c;
        end
        chk("all_off", reg_off_r, 32'h0000_007F);
        for (i = 0; i < 7; i++) for (j = 0; j < 7; j++)
            if (o == 0 || fld(o, i) == fld(o, j)) chk("same_step", 32'(t[j] - t[i]), 0);
            else if (fld(o, i) > fld(o, j)) chk("later_step", 32'(t[j] - t[i] >= 50), 1);
        apb(1'b0, 8'h71, 32'h0000_0000);
        chk("status_done", rd, (o == 0) ? 32'h0000_777F : 32'h0000_077F);
        apb(1'b0, 8'h70, 32'h0000_0000);
        chk("ctrl_delay", rd, 32'h0000_0200);
        // Clock enable low freezes state: a power-up pulse is not seen
        @(posedge clk) begin
            ce <= 1'b0;
            sys_on <= 1'b0;
        end
        @(posedge clk) sys_on <= 1'b1;
        @(posedge clk) ce <= 1'b1;
        #1 chk("ce_freeze", {pd_done_r, reg_off_r}, 32'h0000_00FF);
        @(posedge clk) sys_on <= 1'b0;
        @(posedge clk) sys_on <= 1'b1;
        c = 0;
        while (pd_done_r === 1'b1 && c < 20) begin
            @(posedge clk);
            c++;
        end
        @(posedge clk);
        #1 chk("rearm", {pd_done_r, reg_off_r}, 0);
    endtask
    task end_of_test;
        $display("checks=%0d fails=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        end_of_test;
    end
    initial begin
        nrst = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; sys_on = 1'b0; pd_start = 1'b0; tm_src = 1'b0;
        fail_count = 0; check_count = 0;
        k = $urandom(75);
        fuse = 21'($urandom);
        tfuse = 21'($urandom);
        for (k = 0; k < 3; k++) begin
            do_reset(k == 1);
            for (i = 0; i < 7; i++) begin
                apb(1'b0, 8'h5F + i, 32'h0000_0000);
                chk("init_order", rd, {29'h0, fld(k == 1 ? tfuse : fuse, i)});
            end
            ord = 21'($urandom);
            run_seq(ord, k[0]);
        end
        sys_on <= 1'b0;
        apb(1'b1, 8'h5F, 32'h0000_0007 ^ fld(ord, 0));
        chk("off_write_err", err, 1);
        apb(1'b0, 8'h5F, 32'h0000_0000);
        chk("off_write_kept", rd, {29'h0, fld(ord, 0)});
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", err, 1);
        run_seq(21'h0, 1'b0);
        run_seq({7{3'h3}}, 1'b1);
        run_seq({3'h7, 3'h0, 3'h1, 3'h7, 3'h0, 3'h4, 3'h1}, 1'b0);
        end_of_test;
    end
endmodule
